// [src/ais_cfg.svh]
`ifndef AIS_CFG_SVH
`define AIS_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets inside one channel window
`define AIS_OFS_CTRL 5'h00
`define AIS_OFS_LO_IN 5'h04
`define AIS_OFS_HI_IN 5'h08
`define AIS_OFS_LO_RES 5'h0C
`define AIS_OFS_HI_RES 5'h10
`define AIS_OFS_TARGET 5'h14
`define AIS_OFS_RAW 5'h18
// Channel window is 32 bytes, channel index in address bits 7:5
`define AIS_CH_SHIFT 5
`define AIS_CH_IDX_W 3

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define AIS_CTRL_CLAIM_BIT 0
`define AIS_CTRL_CAP_UP_BIT 1
`define AIS_CTRL_CAP_LO_BIT 2

////////////////////////////////////////////////////////////////////////////////
// Reading scale: hundredths of a percent, 100.00 % full scale
`define AIS_FULL_SCALE 16'h2710

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define AIS_RST_CLAIM 1'b0
`define AIS_RST_LO_IN 16'h0000
`define AIS_RST_HI_IN 16'h2710
`define AIS_RST_LO_RES 32'h00000000
`define AIS_RST_HI_RES 32'h00002710
`define AIS_RST_TARGET 16'h0000
`define AIS_RST_RAW 16'h0000

`endif

// [src/ais_pkg.sv]
package ais_pkg;

  typedef logic [15:0] ais_pct_t;
  typedef logic [31:0] ais_val_t;
  typedef logic [15:0] ais_tgt_t;

  // Scaling engine sequence
  typedef enum logic [1:0] {AIS_IDLE, AIS_DIV, AIS_OUT} ais_state_t;

  // Per-channel configuration and live reading
  typedef struct packed {
    logic claim;
    ais_pct_t lo_in;
    ais_pct_t hi_in;
    ais_val_t lo_res;
    ais_val_t hi_res;
    ais_tgt_t target;
    ais_pct_t raw;
  } ais_chan_t;

endpackage

// [src/ais_div.sv]
`timescale 1ns/1ps
`default_nettype none

module ais_div #(
  parameter int NUM_W = 49,
  parameter int DEN_W = 17
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, low
  input wire logic ce, // Clock enable
  input wire logic start, // Load operands, one cycle
  input wire logic [NUM_W-1:0] num, // Dividend magnitude
  input wire logic [DEN_W-1:0] den, // Divisor magnitude, nonzero
  output logic done, // Quotient valid, one cycle
  output logic [NUM_W-1:0] quo // Quotient, truncated
);

  localparam int CW = $clog2(NUM_W + 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [DEN_W-1:0] rem;
    logic [NUM_W-1:0] quo;
    logic [DEN_W-1:0] den;
  } ais_div_st_t;

  ais_div_st_t st;
  ais_div_st_t nx;
  logic [DEN_W:0] trial;

  ////////////////////////////////////////////////////////////////////////////
  // Restoring division, one quotient bit per cycle; slow but no wide divider
  always_comb begin
    nx = st;
    nx.done = 1'b0;
    trial = {st.rem, st.quo[NUM_W-1]};
    if (start) begin
      nx.busy = 1'b1;
      nx.cnt = CW'(NUM_W);
      nx.rem = '0;
      nx.quo = num;
      nx.den = den;
    end else if (st.busy) begin
      nx.quo = {st.quo[NUM_W-2:0], 1'b0};
      if (trial >= {1'b0, st.den}) begin
        nx.rem = DEN_W'(trial - {1'b0, st.den});
        nx.quo[0] = 1'b1;
      end else begin
        nx.rem = DEN_W'(trial);
      end
      nx.cnt = CW'(st.cnt - 1'b1);
      if (st.cnt == CW'(1)) begin
        nx.busy = 1'b0;
        nx.done = 1'b1;
      end
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= nx;
    end
  end

  assign done = st.done;
  assign quo = st.quo;

endmodule

`default_nettype wire

// [src/ais_top.sv]
// Operation
// - per-channel claim bit; only claimed channels produce scaled results, others stay free
// - reading taken as percent of full scale, 0 to 100 %, before scaling
// - reading equal to upper input point writes exactly the upper result value, unless both input points are equal (lower result then)
// - reading equal to lower input point writes exactly the lower result value
// - other readings straight-line interpolated through both points, then written out; equal input points give the lower result
// - result target selectable per channel, any writable variable
// - read-only unscaled reading, always 0 to 100 %, writes ignored
// - capture-upper copies the channel's current reading into upper input point
// - capture-lower copies the channel's current reading into lower input point
`timescale 1ns/1ps
`default_nettype none
`include "ais_cfg.svh"

module ais_top #(
  parameter int NCH = 3,
  parameter int ADDR_W = 12,
  localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1
) (
  input wire logic pclk, // Bus clock, 200 MHz
  input wire logic presetn, // Async reset, low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, no wait states
  output logic pslverr, // APB error, unmapped address
  input wire logic smp_valid, // New reading offered
  input wire logic [CHW-1:0] smp_chan, // Channel of the reading
  input wire logic [15:0] smp_pct, // Reading, 0.01 % units
  output logic smp_ready, // Reading accepted
  output logic res_valid, // Result write offered
  output logic [15:0] res_target, // Variable to be written
  output logic [31:0] res_data, // Scaled value
  input wire logic res_ready, // Variable store takes the write
  output logic [NCH-1:0] chan_claim // Channel owned by this block
);

  localparam ais_pkg::ais_chan_t CH_RST = '{
    claim: `AIS_RST_CLAIM,
    lo_in: `AIS_RST_LO_IN,
    hi_in: `AIS_RST_HI_IN,
    lo_res: `AIS_RST_LO_RES,
    hi_res: `AIS_RST_HI_RES,
    target: `AIS_RST_TARGET,
    raw: `AIS_RST_RAW
  };

  typedef struct packed {
    ais_pkg::ais_chan_t [NCH-1:0] ch;
    ais_pkg::ais_state_t fsm;
    logic [31:0] rdata;
    logic slverr;
    logic neg;
    logic [31:0] base;
    logic [15:0] tgt;
    logic [31:0] res;
  } ais_st_t;

  ais_st_t st;
  ais_st_t nx;

  // Decode and arithmetic helpers
  logic [`AIS_CH_IDX_W-1:0] a_chn;
  logic [4:0] a_ofs;
  logic a_hit;
  logic [CHW-1:0] a_idx;
  logic [CHW-1:0] s_idx;
  logic [15:0] pct;
  logic signed [16:0] diff;
  logic signed [16:0] span_in;
  logic signed [32:0] span_res;
  logic signed [49:0] prod;
  logic [32:0] qfull;
  logic [31:0] q32;
  logic div_start;
  logic [48:0] div_num;
  logic [16:0] div_den;
  logic div_done;
  logic [48:0] div_quo;

  // Merge written bytes into an old word
  function automatic logic [31:0] ais_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, reading intake, scaling sequence
  always_comb begin
    nx = st;
    a_chn = paddr[`AIS_CH_SHIFT +: `AIS_CH_IDX_W];
    a_ofs = paddr[`AIS_CH_SHIFT-1:0];
    a_hit = (paddr[ADDR_W-1:`AIS_CH_SHIFT+`AIS_CH_IDX_W] == '0) && (int'(a_chn) < NCH) &&
            (a_ofs[1:0] == 2'b00) && (a_ofs <= `AIS_OFS_RAW);
    a_idx = a_hit ? CHW'(a_chn) : '0;
    s_idx = smp_chan;
    pct = (smp_pct > `AIS_FULL_SCALE) ? `AIS_FULL_SCALE : smp_pct;
    diff = $signed({1'b0, pct}) - $signed({1'b0, st.ch[s_idx].lo_in});
    span_in = $signed({1'b0, st.ch[s_idx].hi_in}) - $signed({1'b0, st.ch[s_idx].lo_in});
    span_res = $signed({st.ch[s_idx].hi_res[31], st.ch[s_idx].hi_res}) -
               $signed({st.ch[s_idx].lo_res[31], st.ch[s_idx].lo_res});
    prod = diff * span_res;
    div_start = 1'b0;
    div_num = prod[49] ? 49'(-prod) : prod[48:0];
    div_den = span_in[16] ? 17'(-span_in) : span_in;
    qfull = {1'b0, div_quo[31:0]};
    q32 = st.neg ? (~qfull[31:0] + 32'h00000001) : qfull[31:0];

    // Read data latched in the setup phase so prdata comes from a flop
    if (psel && !penable) begin
      nx.slverr = !a_hit;
      nx.rdata = '0;
      if (a_hit) begin
        case (a_ofs)
          `AIS_OFS_CTRL: nx.rdata[`AIS_CTRL_CLAIM_BIT] = st.ch[a_idx].claim;
          `AIS_OFS_LO_IN: nx.rdata[15:0] = st.ch[a_idx].lo_in;
          `AIS_OFS_HI_IN: nx.rdata[15:0] = st.ch[a_idx].hi_in;
          `AIS_OFS_LO_RES: nx.rdata = st.ch[a_idx].lo_res;
          `AIS_OFS_HI_RES: nx.rdata = st.ch[a_idx].hi_res;
          `AIS_OFS_TARGET: nx.rdata[15:0] = st.ch[a_idx].target;
          `AIS_OFS_RAW: nx.rdata[15:0] = st.ch[a_idx].raw;
          default: nx.rdata = '0;
        endcase
      end
    end

    // Writes take effect at the access edge; raw reading ignores them
    if (psel && penable && pwrite && a_hit) begin
      case (a_ofs)
        `AIS_OFS_CTRL: begin
          if (pstrb[0]) begin
            nx.ch[a_idx].claim = pwdata[`AIS_CTRL_CLAIM_BIT];
            if (pwdata[`AIS_CTRL_CAP_UP_BIT]) begin
              nx.ch[a_idx].hi_in = st.ch[a_idx].raw;
            end
            if (pwdata[`AIS_CTRL_CAP_LO_BIT]) begin
              nx.ch[a_idx].lo_in = st.ch[a_idx].raw;
            end
          end
        end
        `AIS_OFS_LO_IN: nx.ch[a_idx].lo_in = 16'(ais_merge({16'h0000, st.ch[a_idx].lo_in}, pwdata, pstrb));
        `AIS_OFS_HI_IN: nx.ch[a_idx].hi_in = 16'(ais_merge({16'h0000, st.ch[a_idx].hi_in}, pwdata, pstrb));
        `AIS_OFS_LO_RES: nx.ch[a_idx].lo_res = ais_merge(st.ch[a_idx].lo_res, pwdata, pstrb);
        `AIS_OFS_HI_RES: nx.ch[a_idx].hi_res = ais_merge(st.ch[a_idx].hi_res, pwdata, pstrb);
        `AIS_OFS_TARGET: nx.ch[a_idx].target = 16'(ais_merge({16'h0000, st.ch[a_idx].target}, pwdata, pstrb));
        default: nx.rdata = st.rdata;
      endcase
    end

    // Scaling sequence; operands frozen at intake so later bus writes cannot skew a job
    case (st.fsm)
      ais_pkg::AIS_IDLE: begin
        if (smp_valid && (int'(smp_chan) < NCH)) begin
          nx.ch[s_idx].raw = pct;
          if (st.ch[s_idx].claim) begin
            nx.tgt = st.ch[s_idx].target;
            nx.base = st.ch[s_idx].lo_res;
            nx.neg = prod[49] ^ span_in[16];
            nx.fsm = ais_pkg::AIS_OUT;
            if (span_in == 17'sh00000) begin
              nx.res = st.ch[s_idx].lo_res;
            end else if (pct == st.ch[s_idx].hi_in) begin
              nx.res = st.ch[s_idx].hi_res;
            end else if (pct == st.ch[s_idx].lo_in) begin
              nx.res = st.ch[s_idx].lo_res;
            end else begin
              div_start = 1'b1;
              nx.fsm = ais_pkg::AIS_DIV;
            end
          end
        end
      end
      ais_pkg::AIS_DIV: begin
        if (div_done) begin
          nx.res = st.base + q32;
          nx.fsm = ais_pkg::AIS_OUT;
        end
      end
      ais_pkg::AIS_OUT: begin
        if (res_ready) begin
          nx.fsm = ais_pkg::AIS_IDLE;
        end
      end
      default: nx.fsm = ais_pkg::AIS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      for (int i = 0; i < NCH; i++) begin
        st.ch[i] <= CH_RST;
      end
    end else if (ce) begin
      st <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quotient magnitude of reading offset times result span over input span
  ais_div #(
    .NUM_W(49),
    .DEN_W(17)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = st.slverr & psel & penable;
  assign smp_ready = (st.fsm == ais_pkg::AIS_IDLE);
  assign res_valid = (st.fsm == ais_pkg::AIS_OUT);
  assign res_target = st.tgt;
  assign res_data = st.res;

  // Claim bits drive ownership out to the input hardware
  for (genvar g = 0; g < NCH; g++) begin : g_claim
    assign chan_claim[g] = st.ch[g].claim;
  end

endmodule

`default_nettype wire

// [testbench/ais_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ais_top_asserts #(
  parameter int NCH = 3
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Address
  input wire logic pslverr, // Error
  input wire logic smp_valid, // Offered
  input wire logic [1:0] smp_chan, // Channel
  input wire logic smp_ready, // Taken
  input wire logic res_valid, // Result
  input wire logic [15:0] res_target, // Variable
  input wire logic [31:0] res_data, // Value
  input wire logic res_ready, // Stored
  input wire logic [NCH-1:0] chan_claim // Owned
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  // Write access phase, for the claim history
  assign wr_acc = psel & penable & pwrite;
  logic bad_adr;
  // Unmapped access: high page, missing channel, unaligned or past the raw reading
  assign bad_adr = (paddr[11:8] != 4'h0) || (int'(paddr[7:5]) >= NCH) || (paddr[1:0] != 2'h0) ||
                   (paddr[4:0] > 5'h18);
  //////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    smp_valid && smp_ready;
  endsequence
  sequence s_give;
    res_valid && res_ready;
  endsequence
  property p_free;
    s_take ##0 (smp_chan < NCH && !chan_claim[smp_chan]) |=> !res_valid;
  endproperty
  property p_job;
    s_take ##0 chan_claim[smp_chan] |-> ##[1:51] res_valid;
  endproperty
  property p_claim;
    $changed(chan_claim) |-> $past(wr_acc);
  endproperty
  property p_hold;
    res_valid && !res_ready |=> res_valid && $stable(res_data) && $stable(res_target);
  endproperty
  property p_done;
    s_give |=> !res_valid && smp_ready;
  endproperty
  property p_busy;
    res_valid |-> !smp_ready;
  endproperty
  property p_idle;
    chan_claim == 0 && smp_ready |=> !res_valid;
  endproperty
  property p_err;
    pslverr == (psel && penable && bad_adr);
  endproperty
  a_free: assert property (p_free) else $error("result from free channel");
  a_job: assert property (p_job) else $error("claimed reading gave no result");
  a_claim: assert property (p_claim) else $error("claim moved without write");
  a_hold: assert property (p_hold) else $error("result changed while waiting");
  a_done: assert property (p_done) else $error("hand-off did not end job");
  a_busy: assert property (p_busy) else $error("reading taken while busy");
  a_idle: assert property (p_idle) else $error("result unowned");
  a_err: assert property (p_err) else $error("error flag does not match address");
endmodule
bind ais_top ais_top_asserts #(.NCH(NCH)) u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr), .smp_valid(smp_valid), .smp_chan(smp_chan),
  .smp_ready(smp_ready), .res_valid(res_valid), .res_target(res_target), .res_data(res_data),
  .res_ready(res_ready), .chan_claim(chan_claim));
`default_nettype wire

// [testbench/ais_adc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ais_adc_model (
  input wire logic pclk, // Clock
  input wire logic smp_ready, // Taken
  output logic smp_valid, // Offered
  output logic [1:0] smp_chan, // Channel
  output logic [15:0] smp_pct // Reading
);
  initial begin
    smp_valid = 1'b0;
    smp_chan = 2'h0;
    smp_pct = 16'h0;
  end
  // Offer after a gap; held until taken, then lines show inverted data
  task automatic offer(input logic [1:0] c, input logic [15:0] p, input int gap, output bit ok);
    ok = 1'b0;
    repeat (gap) @(posedge pclk);
    smp_valid <= 1'b1;
    smp_chan <= c;
    smp_pct <= p;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge pclk);
      ok = smp_ready;
    end
    smp_valid <= 1'b0;
    smp_chan <= ~c;
    smp_pct <= ~p;
  endtask
endmodule
`default_nettype wire

// [testbench/tb_analog_input_scaler.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_analog_input_scaler;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic res_ready = 1'b0;
  logic ce = 1'b1;
  logic [31:0] prdata, res_data, rq;
  logic pready, pslverr, smp_valid, smp_ready, res_valid, re;
  logic [1:0] smp_chan;
  logic [15:0] smp_pct, res_target;
  logic [2:0] chan_claim;
  int num_errors = 0;
  int comparisons = 0;
  // Clock at 200 MHz
  always #2.5 pclk = ~pclk;
  ais_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_valid(smp_valid), .smp_chan(smp_chan), .smp_pct(smp_pct), .smp_ready(smp_ready),
    .res_valid(res_valid), .res_target(res_target), .res_data(res_data), .res_ready(res_ready),
    .chan_claim(chan_claim));
  ais_adc_model adc (.pclk(pclk), .smp_ready(smp_ready), .smp_valid(smp_valid), .smp_chan(smp_chan),
    .smp_pct(smp_pct));
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    chk(32'h0, 32'h1);
    give_verdict();
  endtask
  // One APB transfer; idle edge after, so no strobe is set twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 9; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 9) hang();
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rq, e);
  endtask
  // Reading through to the variable store, which may stall
  task automatic sc(input logic [1:0] c, input logic [15:0] p, input int s, input logic [31:0] e,
                    input logic [15:0] t);
    bit ok;
    int n;
    adc.offer(c, p, 0, ok);
    if (!ok) hang();
    for (n = 0; n < 99 && res_valid !== 1'b1; n++) @(posedge pclk);
    if (n == 99) hang();
    repeat (s) @(posedge pclk);
    chk(res_data, e);
    chk({16'h0, res_target}, {16'h0, t});
    res_ready <= 1'b1;
    @(posedge pclk);
    res_ready <= 1'b0;
  endtask
  // Unowned channel: reading kept, nothing written out
  task automatic nores(input logic [1:0] c, input logic [15:0] p);
    bit ok;
    adc.offer(c, p, 2, ok);
    if (!ok) hang();
    repeat (3) @(posedge pclk);
    chk({31'h0, res_valid}, 32'h0);
    rd({c, 5'h18}, {16'h0, p});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_map();
    rd(12'h028, 32'h2710);
    apb(1'b1, 12'h018, 32'h55);
    rd(12'h018, 32'h0);
    apb(1'b0, 12'h060, 32'h0);
    chk({31'h0, re}, 32'h1);
    nores(2'h0, 16'h0800);
  endtask
  task automatic t_scale();
    apb(1'b1, 12'h024, 32'h03E8);
    apb(1'b1, 12'h028, 32'h2328);
    apb(1'b1, 12'h02C, 32'hFFFFFF9C);
    apb(1'b1, 12'h030, 32'h64);
    apb(1'b1, 12'h034, 32'h42);
    apb(1'b1, 12'h020, 32'h1);
    apb(1'b1, 12'h054, 32'h7);
    apb(1'b1, 12'h040, 32'h1);
    chk({29'h0, chan_claim}, 32'h6);
    sc(2'h1, 16'h2328, 0, 32'h64, 16'h42);
    sc(2'h1, 16'h03E8, 3, 32'hFFFFFF9C, 16'h42);
    sc(2'h1, 16'h07D0, 0, 32'hFFFFFFB5, 16'h42);
    sc(2'h1, 16'hFFFF, 2, 32'h7D, 16'h42);
    rd(12'h038, 32'h2710);
    sc(2'h2, 16'h1234, 1, 32'h1234, 16'h7);
  endtask
  task automatic t_capture();
    sc(2'h1, 16'h0BB8, 0, 32'hFFFFFFCE, 16'h42);
    apb(1'b1, 12'h020, 32'h3);
    rd(12'h028, 32'h0BB8);
    rd(12'h020, 32'h1);
    apb(1'b1, 12'h020, 32'h5);
    rd(12'h024, 32'h0BB8);
    sc(2'h1, 16'h1F40, 0, 32'hFFFFFF9C, 16'h42);
    apb(1'b1, 12'h020, 32'h0);
    nores(2'h1, 16'h0BB8);
  endtask
  // Clock enable low swallows a claim write; a reading on a missing channel is dropped
  task automatic t_hold();
    bit ok;
    ce <= 1'b0;
    apb(1'b1, 12'h000, 32'h1);
    ce <= 1'b1;
    chk({29'h0, chan_claim}, 32'h4);
    adc.offer(2'h3, 16'h0100, 0, ok);
    if (!ok) hang();
    repeat (3) @(posedge pclk);
    chk({31'h0, res_valid}, 32'h0);
  endtask
  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_map();
    t_scale();
    t_capture();
    t_hold();
    give_verdict();
  end
endmodule
`default_nettype wire
